/* hdl/msbl_top.sv */
// msbl_top: tempo source select, local gating, channel filter and voice bank loader
// assumes rx/tx bytes are one-cycle strobes and the program store accepts one write a cycle
// Summary of operation
// - internal source makes the block master; at a nonzero tempo it emits timing clocks at the tempo period, a key byte in the same cycle going out instead.
// - external source follows received timing clocks, driven by the far master.
// - automatic source follows while clocks arrive and is master otherwise.
// - local on sends keys out, and to the tone generator unless a received byte passing the channel filter takes that cycle; local off only sends them out.
// - channel messages pass only on the configured global channel.
// - only a full 32-voice bank is accepted, single voices are refused.
// - only the first-generation six-operator bank format is accepted.
// - a bank writes 4096 consecutive bytes from address 32 times the selected destination program.
// - the destination may change while the bank waits for confirmation.
// - a bank is held until yes commits it or no discards it.
// - short message or wrong header flags no-readable-data and loads nothing.
// - good header with bad checksum flags unsupported-data and loads nothing.
// - the usb side presents class-compliant midi, so the same stream serves it.
//
// The APB register port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
module msbl_top #(
	parameter int CLK_LOSS_CYC = msbl_pkg::MSBL_CLK_LOSS_CYC,
	parameter int DATA_LEN = msbl_pkg::MSBL_DATA_LEN
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire msbl_pkg::msbl_byte_t rx_byte,
	input wire msbl_pkg::msbl_byte_t key_byte,
	output msbl_pkg::msbl_byte_t tx_byte,
	output msbl_pkg::msbl_byte_t tone_byte,
	output msbl_pkg::msbl_mem_t prog_wr,
	output logic clk_tick,
	output logic irq
);
	import msbl_pkg::*;
	typedef enum logic [2:0] {ST_IDLE, ST_HDR, ST_DATA, ST_SUM, ST_END, ST_PEND, ST_COPY} msbl_st_t;
	typedef struct packed {
		logic [7:0] ctrl;
		logic [15:0] tempo;
		logic [6:0] dest;
		logic [MSBL_IRQ_W-1:0] irq;
		logic [MSBL_IRQ_W-1:0] mask;
		msbl_st_t st;
		logic [12:0] cnt;
		logic [6:0] sum;
		logic [6:0] rsum;
		logic [11:0] widx;
		logic [15:0] tcnt;
		logic [31:0] lcnt;
		logic ext_live;
		logic [3:0] run_ch;
		logic run_chan;
		msbl_byte_t tx;
		msbl_byte_t tone;
		msbl_mem_t wr;
		logic tick;
		logic [31:0] rdata;
	} msbl_state_t;
	msbl_state_t s_reg, s_next;
	// bank held in flip-flops so no commits before yes
	logic [7:0] bank_reg [0:DATA_LEN-1];
	logic bank_we;
	logic [11:0] bank_wa;
	logic acc, wr_acc, rd_acc;
	logic follow;
	logic [6:0] sum_add;
	logic [7:0] rb;
	assign acc = psel && penable;
	assign wr_acc = acc && pwrite;
	// read data is captured in setup so it stands through the zero-wait access
	assign rd_acc = psel && !pwrite;
	assign pready = 1'b1;
	assign rb = rx_byte.data;
	//////////////////////////////////////////////////////////////////////
	// follow select: external, or automatic while clocks are live
	assign follow = (msbl_src_t'(s_reg.ctrl[MSBL_CTRL_SRC_LSB +: 2]) == MSBL_SRC_EXT) ||
		((msbl_src_t'(s_reg.ctrl[MSBL_CTRL_SRC_LSB +: 2]) == MSBL_SRC_AUTO) && s_reg.ext_live);
	assign sum_add = s_reg.sum + rb[6:0];
	always_comb begin
		s_next = s_reg;
		s_next.tick = 1'b0;
		s_next.tx = '0;
		s_next.tone = '0;
		s_next.wr = '0;
		bank_we = 1'b0;
		bank_wa = s_reg.cnt[11:0];
		pslverr = 1'b0;
		//////////////////////////////////////////////////////////////////
		// apb slave, decode by if chain
		if (rd_acc) begin
			if (paddr == MSBL_CTRL_OFF) begin
				s_next.rdata = {24'h00_0000, s_reg.ctrl};
			end else if (paddr == MSBL_TEMPO_OFF) begin
				s_next.rdata = {16'h0000, s_reg.tempo};
			end else if (paddr == MSBL_DEST_OFF) begin
				s_next.rdata = {25'h000_0000, s_reg.dest};
			end else if (paddr == MSBL_STAT_OFF) begin
				s_next.rdata = {27'h000_0000, follow, 1'b0, s_reg.st};
			end else if (paddr == MSBL_IRQ_OFF) begin
				s_next.rdata = {28'h000_0000, s_reg.irq};
			end else if (paddr == MSBL_MASK_OFF) begin
				s_next.rdata = {28'h000_0000, s_reg.mask};
			end else if (paddr == MSBL_WIN_OFF) begin
				s_next.rdata = {24'h00_0000, bank_reg[s_reg.widx]};
			end else begin
				s_next.rdata = 32'h0000_0000;
				pslverr = penable;
			end
		end
		if (wr_acc) begin
			if (paddr == MSBL_CTRL_OFF) begin
				s_next.ctrl = pwdata[7:0];
			end else if (paddr == MSBL_TEMPO_OFF) begin
				s_next.tempo = pwdata[15:0];
			end else if (paddr == MSBL_DEST_OFF) begin
				if (s_reg.st != ST_COPY) begin
					s_next.dest = pwdata[6:0];
				end
			end else if (paddr == MSBL_IRQ_OFF) begin
				s_next.irq = s_reg.irq & ~pwdata[MSBL_IRQ_W-1:0];
			end else if (paddr == MSBL_MASK_OFF) begin
				s_next.mask = pwdata[MSBL_IRQ_W-1:0];
			end else if (paddr == MSBL_WIN_OFF) begin
				s_next.widx = pwdata[11:0];
			end else if (paddr == MSBL_CMD_OFF) begin
				if (s_reg.st == ST_PEND && pwdata[MSBL_CMD_YES]) begin
					s_next.st = ST_COPY;
					s_next.cnt = '0;
				end else if (s_reg.st == ST_PEND && pwdata[MSBL_CMD_NO]) begin
					s_next.st = ST_IDLE;
				end
			end else begin
				pslverr = 1'b1;
			end
		end
		//////////////////////////////////////////////////////////////////
		// internal master clock
		if (!follow) begin
			if (s_reg.tcnt + 16'h0001 >= s_reg.tempo && s_reg.tempo >= 16'(MSBL_TEMPO_MIN)) begin
				s_next.tcnt = '0;
				s_next.tick = 1'b1;
				s_next.tx = '{valid: 1'b1, data: MSBL_CLK};
			end else begin
				s_next.tcnt = s_reg.tcnt + 16'h0001;
			end
		end
		if (rx_byte.valid && rb == MSBL_CLK) begin
			s_next.lcnt = '0;
			s_next.ext_live = 1'b1;
			if (follow) begin
				s_next.tick = 1'b1;
			end
		end else if (s_reg.lcnt >= 32'(CLK_LOSS_CYC)) begin
			s_next.ext_live = 1'b0;
		end else begin
			s_next.lcnt = s_reg.lcnt + 32'h0000_0001;
		end
		if (key_byte.valid) begin
			s_next.tx = key_byte;
			if (s_reg.ctrl[MSBL_CTRL_LOCAL_BIT]) begin
				s_next.tone = key_byte;
			end
		end
		if (rx_byte.valid && rb[7] && rb < MSBL_SOX) begin
			s_next.run_chan = (rb[3:0] == s_reg.ctrl[MSBL_CTRL_CHAN_LSB +: 4]);
		end
		if (rx_byte.valid && rb < MSBL_SOX) begin
			if (rb[7] ? (rb[3:0] == s_reg.ctrl[MSBL_CTRL_CHAN_LSB +: 4]) : s_reg.run_chan) begin
				s_next.tone = rx_byte;
			end
		end
		//////////////////////////////////////////////////////////////////
		// sysex receiver
		if (rx_byte.valid && rb < MSBL_CLK && s_reg.st != ST_PEND && s_reg.st != ST_COPY) begin
			s_next.cnt = s_reg.cnt + 13'h0001;
			if (rb == MSBL_SOX) begin
				s_next.st = ST_HDR;
				s_next.cnt = 13'h0001;
				s_next.sum = '0;
			end else if (s_reg.st == ST_IDLE) begin
				s_next.cnt = s_reg.cnt;
			end else if (rb == MSBL_EOX) begin
				s_next.st = ST_IDLE;
				if (s_reg.st != ST_END) begin
					s_next.irq[MSBL_IRQ_NODATA] = 1'b1;
				end else if (((~s_reg.sum) + 7'h01) != s_reg.rsum) begin
					s_next.irq[MSBL_IRQ_UNSUP] = 1'b1;
				end else begin
					s_next.st = ST_PEND;
					s_next.irq[MSBL_IRQ_PEND] = 1'b1;
				end
			end else if (rb[7]) begin
				s_next.st = ST_IDLE;
			end else if (s_reg.st == ST_HDR) begin
				if ((s_reg.cnt == 13'h0001 && rb != MSBL_HDR_VENDOR) ||
					(s_reg.cnt == 13'h0003 && rb != MSBL_HDR_FMT) ||
					(s_reg.cnt == 13'h0004 && rb != MSBL_HDR_CNT_HI) ||
					(s_reg.cnt == 13'h0005 && rb != MSBL_HDR_CNT_LO)) begin
					s_next.st = ST_IDLE;
					s_next.irq[MSBL_IRQ_NODATA] = 1'b1;
				end else if (s_reg.cnt == 13'(MSBL_HDR_LEN - 1)) begin
					s_next.st = ST_DATA;
					s_next.cnt = '0;
				end
			end else if (s_reg.st == ST_DATA) begin
				bank_we = 1'b1;
				s_next.sum = sum_add;
				if (s_reg.cnt == 13'(DATA_LEN - 1)) begin
					s_next.st = ST_SUM;
				end
			end else if (s_reg.st == ST_SUM) begin
				s_next.rsum = rb[6:0];
				s_next.st = ST_END;
			end else begin
				s_next.st = ST_IDLE;
				s_next.irq[MSBL_IRQ_NODATA] = 1'b1;
			end
		end
		if (s_reg.st == ST_COPY) begin
			s_next.wr.we = 1'b1;
			s_next.wr.addr = 12'({s_reg.dest, 5'b00000}) + s_reg.cnt[11:0];
			s_next.wr.data = bank_reg[s_reg.cnt[11:0]];
			s_next.cnt = s_reg.cnt + 13'h0001;
			if (s_reg.cnt == 13'(DATA_LEN - 1)) begin
				s_next.st = ST_IDLE;
				s_next.irq[MSBL_IRQ_DONE] = 1'b1;
			end
		end
	end
	//////////////////////////////////////////////////////////////////////
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_reg <= '0;
			s_reg.ctrl <= MSBL_CTRL_RESET;
			s_reg.tempo <= MSBL_TEMPO_RESET;
		end else begin
			s_reg <= s_next;
		end
	end
	always_ff @(posedge pclk) begin
		if (bank_we) begin
			bank_reg[bank_wa] <= rb;
		end
	end
	assign prdata = s_reg.rdata;
	assign tx_byte = s_reg.tx;
	assign tone_byte = s_reg.tone;
	assign prog_wr = s_reg.wr;
	assign clk_tick = s_reg.tick;
	assign irq = |(s_reg.irq & s_reg.mask);
	//////////////////////////////////////////////////////////////////////
	// nothing written unless copying
	AST_NO_WR_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
		s_reg.wr.we |-> $past(s_reg.st) == ST_COPY)
		else $error("write outside copy");
	// tick carries a clock, key bytes win the slot
	AST_INT_TICK: assert property (@(posedge pclk) disable iff (!presetn)
		s_reg.tick && !$past(follow) && !$past(key_byte.valid) |-> s_reg.tx.data == MSBL_CLK)
		else $error("tick no clock");
	AST_LOCAL_OFF: assert property (@(posedge pclk) disable iff (!presetn)
		key_byte.valid && !s_reg.ctrl[MSBL_CTRL_LOCAL_BIT] && !rx_byte.valid |=> !s_reg.tone.valid)
		else $error("local off sounded");
	AST_LOCAL_ON: assert property (@(posedge pclk) disable iff (!presetn)
		key_byte.valid && s_reg.ctrl[MSBL_CTRL_LOCAL_BIT] |=> s_reg.tone.valid)
		else $error("local on silent");
	AST_KEY_OUT: assert property (@(posedge pclk) disable iff (!presetn)
		key_byte.valid |=> s_reg.tx.valid)
		else $error("key not sent");
	AST_CHAN: assert property (@(posedge pclk) disable iff (!presetn)
		rx_byte.valid && rb[7] && rb < MSBL_SOX && !key_byte.valid &&
		rb[3:0] != s_reg.ctrl[MSBL_CTRL_CHAN_LSB +: 4] |=> !s_reg.tone.valid)
		else $error("foreign channel sounded");
	AST_PEND_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
		s_reg.st == ST_PEND && !wr_acc |=> s_reg.st == ST_PEND)
		else $error("pend lost");
	AST_YES_CMD: assert property (@(posedge pclk) disable iff (!presetn)
		s_reg.st == ST_PEND && wr_acc && paddr == MSBL_CMD_OFF && pwdata[MSBL_CMD_YES]
		|=> s_reg.st == ST_COPY ##1 s_reg.wr.we)
		else $error("yes not committed");
	AST_NO_CMD: assert property (@(posedge pclk) disable iff (!presetn)
		s_reg.st == ST_PEND && wr_acc && paddr == MSBL_CMD_OFF && pwdata[MSBL_CMD_NO] &&
		!pwdata[MSBL_CMD_YES] |=> s_reg.st == ST_IDLE)
		else $error("no not discarded");
	AST_DEST_PEND: assert property (@(posedge pclk) disable iff (!presetn)
		s_reg.st == ST_PEND && wr_acc && paddr == MSBL_DEST_OFF |=> s_reg.dest == $past(pwdata[6:0]))
		else $error("dest not taken");
	// other status drops a partial bank
	AST_ABANDON: assert property (@(posedge pclk) disable iff (!presetn)
		s_reg.st == ST_DATA && rx_byte.valid && rb[7] && rb < MSBL_CLK && rb != MSBL_SOX
		|=> s_reg.st == ST_IDLE)
		else $error("partial kept");
	AST_HDR_REJ: assert property (@(posedge pclk) disable iff (!presetn)
		s_reg.st == ST_HDR && rx_byte.valid && !rb[7] && s_reg.cnt == 13'h0003 && rb != MSBL_HDR_FMT
		|=> s_reg.st == ST_IDLE && s_reg.irq[MSBL_IRQ_NODATA])
		else $error("bad header kept");
	// early eox is a short message
	AST_SHORT: assert property (@(posedge pclk) disable iff (!presetn)
		(s_reg.st == ST_HDR || s_reg.st == ST_DATA || s_reg.st == ST_SUM) && rx_byte.valid &&
		rb == MSBL_EOX |=> s_reg.st == ST_IDLE && s_reg.irq[MSBL_IRQ_NODATA])
		else $error("short bank kept");
	// data plus checksum must cancel to zero
	AST_SUM_BAD: assert property (@(posedge pclk) disable iff (!presetn)
		s_reg.st == ST_END && rx_byte.valid && rb == MSBL_EOX && 7'(s_reg.sum + s_reg.rsum) != 7'h00
		|=> s_reg.irq[MSBL_IRQ_UNSUP] && s_reg.st == ST_IDLE)
		else $error("bad checksum kept");
	AST_EXT_TICK: assert property (@(posedge pclk) disable iff (!presetn)
		follow && rx_byte.valid && rb == MSBL_CLK |=> s_reg.tick)
		else $error("no follow");
	AST_WR_ADDR: assert property (@(posedge pclk) disable iff (!presetn)
		s_reg.wr.we && $past(s_reg.wr.we) |-> s_reg.wr.addr == $past(s_reg.wr.addr) + 12'h001)
		else $error("slots not consecutive");
	COV_PEND: cover property (@(posedge pclk) s_reg.st == ST_PEND);
	COV_DONE: cover property (@(posedge pclk) s_reg.irq[MSBL_IRQ_DONE]);
	COV_UNSUP: cover property (@(posedge pclk) s_reg.irq[MSBL_IRQ_UNSUP]);
	COV_AUTO: cover property (@(posedge pclk) s_reg.ext_live && follow);
endmodule

/* hdl/msbl_pkg.sv */
// msbl_pkg: register map, field layout, timing and stream types for the midi bank loader
// assumes a byte-wide midi stream already framed by a uart or usb-midi front end
package msbl_pkg;
	localparam logic [11:0] MSBL_CTRL_OFF = 12'h000;
	localparam logic [11:0] MSBL_TEMPO_OFF = 12'h004;
	localparam logic [11:0] MSBL_DEST_OFF = 12'h008;
	localparam logic [11:0] MSBL_STAT_OFF = 12'h00C;
	localparam logic [11:0] MSBL_IRQ_OFF = 12'h010;
	localparam logic [11:0] MSBL_MASK_OFF = 12'h014;
	localparam logic [11:0] MSBL_CMD_OFF = 12'h018;
	localparam logic [11:0] MSBL_WIN_OFF = 12'h01C;
	// ctrl fields
	localparam int MSBL_CTRL_SRC_LSB = 0;
	localparam int MSBL_CTRL_LOCAL_BIT = 2;
	localparam int MSBL_CTRL_CHAN_LSB = 4;
	localparam logic [7:0] MSBL_CTRL_RESET = 8'h04;
	localparam logic [15:0] MSBL_TEMPO_RESET = 16'h0000;
	// irq bits
	localparam int MSBL_IRQ_PEND = 0;
	localparam int MSBL_IRQ_NODATA = 1;
	localparam int MSBL_IRQ_UNSUP = 2;
	localparam int MSBL_IRQ_DONE = 3;
	localparam int MSBL_IRQ_W = 4;
	// cmd bits
	localparam int MSBL_CMD_YES = 0;
	localparam int MSBL_CMD_NO = 1;
	// bank format
	localparam int MSBL_VOICES = 32;
	localparam int MSBL_BANK_LEN = 4104;
	localparam int MSBL_DATA_LEN = 4096;
	localparam int MSBL_HDR_LEN = 6;
	localparam logic [7:0] MSBL_SOX = 8'hF0;
	localparam logic [7:0] MSBL_EOX = 8'hF7;
	localparam logic [7:0] MSBL_CLK = 8'hF8;
	localparam logic [7:0] MSBL_HDR_FMT = 8'h09;
	localparam logic [7:0] MSBL_HDR_CNT_HI = 8'h20;
	localparam logic [7:0] MSBL_HDR_CNT_LO = 8'h00;
	// vendor byte of the sysex header; arbitrary value
	localparam logic [7:0] MSBL_HDR_VENDOR = 8'h7D;
	// clock detect timeout
	localparam int MSBL_CLK_HZ = 200_000_000;
	localparam int MSBL_CLK_LOSS_MS = 500;
	localparam int MSBL_CLK_LOSS_CYC = MSBL_CLK_HZ / 1000 * MSBL_CLK_LOSS_MS;
	localparam int MSBL_TEMPO_MIN = 1;
	typedef enum logic [1:0] {MSBL_SRC_INT, MSBL_SRC_EXT, MSBL_SRC_AUTO} msbl_src_t;
	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} msbl_byte_t;
	typedef struct packed {
		logic we;
		logic [11:0] addr;
		logic [7:0] data;
	} msbl_mem_t;
endpackage

/* sim/msbl_midi_src.sv */
// msbl_midi_src: far-side midi sender model driving the received byte stream
// assumes one caller at a time; bytes are sent one every two clocks
`timescale 1ns/10ps
module msbl_midi_src (
	input wire logic pclk,
	output msbl_pkg::msbl_byte_t rx_byte
);
	import msbl_pkg::*;
	initial begin
		rx_byte = '0;
	end
	////////////////////////////////////////////////////////////////
	// idle data shows the inverse of the last byte, never a stale copy
	task automatic send(input logic [7:0] b);
		@(posedge pclk);
		rx_byte <= '{valid: 1'b1, data: b};
		@(posedge pclk);
		rx_byte <= '{valid: 1'b0, data: ~b};
	endtask
	////////////////////////////////////////////////////////////////
	// bank sent with n data bytes, short of a whole bank when n is under 4096
	// a timing clock is mixed in before data byte 1000, as a live master would do
	task automatic send_bank(input logic [7:0] fmt, input logic [7:0] flip, input int n);
		logic [7:0] sum;
		sum = 8'h00;
		send(MSBL_SOX);
		send(MSBL_HDR_VENDOR);
		send(8'h00);
		send(fmt);
		send(MSBL_HDR_CNT_HI);
		send(MSBL_HDR_CNT_LO);
		for (int i = 0; i < n; i++) begin
			if (i == 1000) begin
				send(MSBL_CLK);
			end
			send(8'(i % 128));
			sum = sum + 8'(i % 128);
		end
		send(((~sum + 8'h01) & 8'h7F) ^ flip);
		send(MSBL_EOX);
	endtask
endmodule

/* sim/msbl_top_tb_top.sv */
// msbl_top_tb_top: self-checking bench for the midi bank loader
// assumes msbl_pkg and the far-side sender model are compiled first
`timescale 1ns/10ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_total++; \
	$display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module msbl_top_tb_top;
	import msbl_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, clk_tick, irq, perr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	msbl_byte_t rx_byte, key_byte, tx_byte, tone_byte;
	msbl_mem_t prog_wr;
	int err_total, compares, ticks, txclk, txkey, tones, wr_cnt, wr_bad, base;
	msbl_top #(.CLK_LOSS_CYC(200)) u_dut(.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_byte(rx_byte),
		.key_byte(key_byte), .tx_byte(tx_byte), .tone_byte(tone_byte),
		.prog_wr(prog_wr), .clk_tick(clk_tick), .irq(irq));
	msbl_midi_src u_src(.pclk(pclk), .rx_byte(rx_byte));
	initial begin
		pclk = 0;
		forever #2.5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		if (clk_tick) ticks <= ticks + 1;
		if (tone_byte.valid) tones <= tones + 1;
		if (tx_byte.valid && tx_byte.data == MSBL_CLK) txclk <= txclk + 1;
		if (tx_byte.valid && tx_byte.data != MSBL_CLK) txkey <= txkey + 1;
		if (prog_wr.we) begin
			if (prog_wr.addr !== 12'(base + wr_cnt) || prog_wr.data !== 8'(wr_cnt % 128))
				wr_bad <= wr_bad + 1;
			wr_cnt <= wr_cnt + 1;
		end
	end
	////////////////////////////////////////////////////////////////
	task automatic finish_test;
		$display("compares=%0d err_total=%0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// one transfer: setup, then access until pready
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 100);
		if (n == 100) err_total++;
		rdat = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a);
		apb(1'b0, a, 32'h0000_0000);
	endtask
	// let pulses in flight drain before clearing the counters
	task automatic zero;
		repeat (2) @(posedge pclk);
		ticks = 0;
		txclk = 0;
		txkey = 0;
		tones = 0;
	endtask
	task automatic key(input logic [7:0] b);
		@(posedge pclk);
		key_byte <= '{valid: 1'b1, data: b};
		@(posedge pclk);
		key_byte <= '{valid: 1'b0, data: ~b};
		repeat (4) @(posedge pclk);
	endtask
	task automatic irq_is(input logic e);
		repeat (2) @(negedge pclk);
		`CHK(irq, e)
	endtask
	task automatic bank(input logic [7:0] f, input logic [7:0] x, input int n, input int e);
		u_src.send_bank(f, x, n);
		repeat (20) @(posedge pclk);
		rd(MSBL_IRQ_OFF);
		`CHK(rdat[3:0], 4'(1 << e))
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_regs;
		rd(MSBL_CTRL_OFF);
		`CHK(rdat[7:0], MSBL_CTRL_RESET)
		rd(MSBL_TEMPO_OFF);
		`CHK(rdat[15:0], MSBL_TEMPO_RESET)
		apb(1'b0, 12'h100, 32'h0000_0000);
		`CHK(perr, 1'b1)
	endtask
	task automatic t_local;
		zero();
		key(8'h90);
		`CHK(tones, 1)
		`CHK(txkey, 1)
		apb(1'b1, MSBL_CTRL_OFF, 32'h0000_0030);
		zero();
		key(8'h90);
		`CHK(tones, 0)
		`CHK(txkey, 1)
		zero();
		u_src.send(8'h93); u_src.send(8'h40); u_src.send(8'h7F);
		u_src.send(8'h94); u_src.send(8'h40); u_src.send(8'h7F);
		repeat (4) @(posedge pclk);
		`CHK(tones, 3)
	endtask
	task automatic t_sync;
		apb(1'b1, MSBL_TEMPO_OFF, 32'h0000_0004);
		apb(1'b1, MSBL_CTRL_OFF, 32'h0000_0004);
		zero();
		repeat (100) @(posedge pclk);
		`CHK(ticks >= 24 && ticks <= 26, 1'b1)
		`CHK(txclk >= 24 && txclk <= 26, 1'b1)
		apb(1'b1, MSBL_CTRL_OFF, 32'h0000_0005);
		zero();
		repeat (5) u_src.send(MSBL_CLK);
		repeat (4) @(posedge pclk);
		`CHK(ticks, 5)
		`CHK(txclk, 0)
		apb(1'b1, MSBL_CTRL_OFF, 32'h0000_0006);
		u_src.send(MSBL_CLK);
		rd(MSBL_STAT_OFF);
		`CHK(rdat[4], 1'b1)
		repeat (300) @(posedge pclk);
		rd(MSBL_STAT_OFF);
		`CHK(rdat[4], 1'b0)
		apb(1'b1, MSBL_TEMPO_OFF, 32'h0000_0000);
		apb(1'b1, MSBL_CTRL_OFF, 32'h0000_0004);
	endtask
	task automatic t_banks;
		int n;
		apb(1'b1, MSBL_MASK_OFF, 32'h0000_0000);
		bank(8'h08, 8'h00, MSBL_DATA_LEN, MSBL_IRQ_NODATA);
		irq_is(1'b0);
		apb(1'b1, MSBL_MASK_OFF, 32'h0000_000F);
		irq_is(1'b1);
		apb(1'b1, MSBL_IRQ_OFF, 32'h0000_000F);
		irq_is(1'b0);
		bank(8'h09, 8'h00, 100, MSBL_IRQ_NODATA);
		apb(1'b1, MSBL_IRQ_OFF, 32'h0000_000F);
		bank(8'h09, 8'h01, MSBL_DATA_LEN, MSBL_IRQ_UNSUP);
		apb(1'b1, MSBL_IRQ_OFF, 32'h0000_000F);
		u_src.send(MSBL_SOX);
		u_src.send(MSBL_HDR_VENDOR);
		u_src.send(8'h90);
		repeat (4) @(posedge pclk);
		rd(MSBL_STAT_OFF);
		`CHK(rdat[2:0], 3'h0)
		rd(MSBL_IRQ_OFF);
		`CHK(rdat[3:0], 4'h0)
		bank(8'h09, 8'h00, MSBL_DATA_LEN, MSBL_IRQ_PEND);
		apb(1'b1, MSBL_CMD_OFF, 32'h0000_0002);
		repeat (50) @(posedge pclk);
		`CHK(wr_cnt, 0)
		apb(1'b1, MSBL_IRQ_OFF, 32'h0000_000F);
		bank(8'h09, 8'h00, MSBL_DATA_LEN, MSBL_IRQ_PEND);
		apb(1'b1, MSBL_DEST_OFF, 32'h0000_0005);
		base = 5 * MSBL_VOICES;
		apb(1'b1, MSBL_CMD_OFF, 32'h0000_0001);
		n = 0;
		while (wr_cnt < MSBL_DATA_LEN && n < 6000) begin
			@(posedge pclk);
			n++;
		end
		repeat (20) @(posedge pclk);
		`CHK(wr_cnt, MSBL_DATA_LEN)
		`CHK(wr_bad, 0)
		rd(MSBL_IRQ_OFF);
		`CHK(rdat[MSBL_IRQ_DONE], 1'b1)
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		#(100_000 * 5);
		err_total++;
		finish_test();
	end
	initial begin
		psel = 0;
		penable = 0;
		pwrite = 0;
		paddr = '0;
		pwdata = '0;
		key_byte = '0;
		presetn = 0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_local();
		t_sync();
		t_banks();
		finish_test();
	end
endmodule
